// [bench/adc_source.sv]
// Converter stand-in: one sample every eight clocks, square-wave voltage, no current
`timescale 1ns/1ns
`default_nettype none
module adc_source (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] half_i,
   input wire logic [15:0] amp_i,
   input wire logic [31:0] act_i,
   output logic sample_valid_o,
   output meter_cal_pkg::sample_t sample_o
);
   logic [2:0] tick_q;
   logic [7:0] cnt_q;
   logic neg_q;
   assign sample_valid_o = tick_q == 3'h7;
   assign sample_o = {neg_q ? -amp_i : amp_i, 16'h0000, act_i};
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tick_q <= 3'h0;
         cnt_q <= 8'h00;
         neg_q <= 1'b0;
      end else begin
         tick_q <= tick_q + 3'h1;
         if (sample_valid_o && half_i != 8'h00) begin
            cnt_q <= cnt_q + 8'h01 == half_i ? 8'h00 : cnt_q + 8'h01;
            neg_q <= neg_q ^ (cnt_q + 8'h01 == half_i);
         end
      end
   end
endmodule
`default_nettype wire

// [bench/meter_calibration_datapath_bench.sv]
// Self-checking bench: register map, rms offsets, energy scaling, zero-cross and line-cycle events
`timescale 1ns/1ns
`default_nettype none
module meter_calibration_datapath_bench;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h00000000;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic irq_o;
   logic sample_valid_i;
   meter_cal_pkg::sample_t sample_i;
   logic [7:0] half = 8'h00;
   logic [15:0] amp = 16'h0000;
   logic [31:0] act = 32'h00000000;
   logic [31:0] rd;
   logic [31:0] v;
   logic [33:0] em;
   logic [33:0] exp_q[$];
   logic last_neg = 1'b0;
   int since = 0;
   int errors = 0;
   int check_count = 0;
   int base;
   int lat;
   always #4 clk_i = ~clk_i;
   meter_calibration_datapath meter_calibration_datapath_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
      .sample_i(sample_i), .irq_o(irq_o));
   adc_source adc_source_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .half_i(half), .amp_i(amp), .act_i(act),
      .sample_valid_o(sample_valid_i), .sample_o(sample_i));
   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask
   // Expectation word: check data, expect error, data
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 100);
      rd = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 100) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, 34'h0);
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h00000000, {2'b10, e});
   endtask
   // Two reads exactly 32 clocks apart frame exactly four samples
   task automatic energy(input logic [31:0] d);
      repeat (40) @(posedge clk_i);
      apb(1'b0, meter_cal_pkg::OFS_VA_TOTAL, 32'h00000000, 34'h0);
      v = rd;
      repeat (28) @(posedge clk_i);
      rdc(meter_cal_pkg::OFS_VA_TOTAL, v + d);
   endtask
   task automatic wait_irq();
      int n;
      repeat (2) @(posedge clk_i);
      for (n = 0; n < 3000 && irq_o !== 1'b1; n++)
         @(posedge clk_i);
      lat = since;
      if (n >= 3000) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic zx(input logic [5:0] t);
      wr(meter_cal_pkg::OFS_PHASE_TRIM, {26'h0, t});
      repeat (400) @(posedge clk_i);
      wr(meter_cal_pkg::OFS_STATUS, 32'h00000003);
      wait_irq();
   endtask
   always @(posedge clk_i) begin
      since <= since + 1;
      if (sample_valid_i && sample_i.volt[15] != last_neg)
         since <= 0;
      if (sample_valid_i)
         last_neg <= sample_i.volt[15];
      if (pready_o === 1'b1) begin
         em = exp_q.pop_front();
         if (em[33])
            cmp("prdata", em[31:0], prdata_o);
         cmp("pslverr", {31'h0, em[32]}, {31'h0, pslverr_o});
      end
   end
   initial begin
      v = $urandom(32'hA6E7);
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 9; i++)
         rdc(8'(4 * i), i == 0 ? 32'h0000000D : i == 4 ? 32'h00000001 : 32'h00000000);
      v = $urandom;
      wr(meter_cal_pkg::OFS_VOLT_OFS, v);
      rdc(meter_cal_pkg::OFS_VOLT_OFS, {{20{v[11]}}, v[11:0]});
      wr(meter_cal_pkg::OFS_PHASE_TRIM, v);
      rdc(meter_cal_pkg::OFS_PHASE_TRIM, {{26{v[5]}}, v[5:0]});
      apb(1'b1, 8'h38, v, {2'b01, 32'h00000000});
      apb(1'b0, 8'h06, 32'h00000000, {2'b11, 32'h00000000});
      wr(meter_cal_pkg::OFS_VA_LINE, v);
      rdc(meter_cal_pkg::OFS_VA_LINE, 32'h00000000);
      wr(meter_cal_pkg::OFS_VOLT_OFS, 32'hFFFFFF9C);
      repeat (32) @(posedge clk_i);
      rdc(meter_cal_pkg::OFS_VOLT_RMS, 32'h00000000);
      wr(meter_cal_pkg::OFS_VOLT_OFS, 32'h000007FF);
      wr(meter_cal_pkg::OFS_CURR_OFS, 32'h000007FF);
      repeat (32) @(posedge clk_i);
      rdc(meter_cal_pkg::OFS_VOLT_RMS, 32'h000007FF);
      rdc(meter_cal_pkg::OFS_CURR_RMS, 32'h00001FFD);
      energy(32'h000003FC);
      wr(meter_cal_pkg::OFS_GAIN, 32'h000007FF);
      energy(32'h000005FC);
      wr(meter_cal_pkg::OFS_GAIN, 32'hFFFFF800);
      energy(32'h000001FC);
      wr(meter_cal_pkg::OFS_GAIN, 32'h00000000);
      wr(meter_cal_pkg::OFS_DIVIDER, 32'h00000002);
      energy(32'h000001FE);
      wr(meter_cal_pkg::OFS_DIVIDER, 32'h00000000);
      energy(32'h000003FC);
      // Offset touched again only after the gain runs, in the host's calibration order
      wr(meter_cal_pkg::OFS_CURR_OFS, 32'h00000000);
      // An 80-sample half period outlasts the longest tap delay, so each crossing is timed alone
      half <= 8'h50;
      amp <= 16'h03E8;
      repeat (1400) @(posedge clk_i);
      rdc(meter_cal_pkg::OFS_STATUS, 32'h00000001);
      cmp("irq", 32'h00000000, {31'h0, irq_o});
      wr(meter_cal_pkg::OFS_MASK, 32'h00000001);
      repeat (3) @(posedge clk_i);
      cmp("irq", 32'h00000001, {31'h0, irq_o});
      zx(6'h0D);
      base = lat;
      for (int i = 0; i < 4; i++) begin
         zx(i == 0 ? 6'h1F : i == 1 ? 6'h00 : i == 2 ? 6'h3F : 6'h20);
         cmp("shift", 32'(i == 0 ? 144 : i == 1 ? -104 : i == 2 ? -112 : -360), 32'(lat - base));
      end
      act <= $urandom & 32'h0000FFFF;
      wr(meter_cal_pkg::OFS_MASK, 32'h00000002);
      wr(meter_cal_pkg::OFS_LINE_CYCLES, 32'h00000002);
      wr(meter_cal_pkg::OFS_MODE, 32'h00000001);
      wr(meter_cal_pkg::OFS_STATUS, 32'h00000003);
      wait_irq();
      wr(meter_cal_pkg::OFS_STATUS, 32'h00000003);
      wait_irq();
      rdc(meter_cal_pkg::OFS_ACT_LINE, act * 32'h000000A0);
      rdc(meter_cal_pkg::OFS_VA_LINE, 32'h00000000);
      finish_test();
   end
endmodule
`default_nettype wire

// [bench/meter_calibration_datapath_props.sv]
// Timing checks on the register bus answer and the interrupt line
`timescale 1ns/1ns
`default_nettype none
module meter_calibration_datapath_props (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sample_valid_i,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire logic wr_done = pready_o && psel_i && pwrite_i;
   wire logic bad_addr = paddr_i > 8'h34 || paddr_i[1:0] != 2'h0;
   wire logic mask_wr = wr_done && paddr_i == meter_cal_pkg::OFS_MASK;
   wire logic stat_wr = wr_done && paddr_i == meter_cal_pkg::OFS_STATUS;
   sequence s_access;
      psel_i && penable_i && !pready_o;
   endsequence
   // A sample in the clearing cycle would win over the clear
   sequence s_clear_all;
      stat_wr && pwdata_i[1:0] == 2'h3 && !sample_valid_i;
   endsequence
   property p_one_wait;
      s_access |=> pready_o ##1 !pready_o;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("bus answer not after one wait state");
   property p_bad_err;
      s_access ##0 bad_addr |=> pslverr_o && prdata_o == 32'h00000000;
   endproperty
   a_bad_err: assert property (p_bad_err) else $error("unmapped access not refused");
   property p_good_ok;
      s_access ##0 !bad_addr |=> !pslverr_o;
   endproperty
   a_good_ok: assert property (p_good_ok) else $error("mapped access refused");
   property p_idle_zero;
      !pready_o |-> prdata_o == 32'h00000000 && !pslverr_o;
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("bus outputs not quiet between answers");
   property p_ready_cause;
      pready_o |-> $past(psel_i && penable_i);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("answer without access");
   // Events move the line at their own edge, mask writes one edge later
   property p_irq_rise;
      $rose(irq_o) |-> $past(sample_valid_i) || $past(mask_wr, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without event");
   property p_irq_fall;
      $fell(irq_o) |-> $past(stat_wr) || $past(mask_wr, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without clear");
   property p_irq_clear;
      s_clear_all |-> ##1 !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt stayed after clear");
endmodule
bind meter_calibration_datapath meter_calibration_datapath_props meter_calibration_datapath_props_i (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .sample_valid_i(sample_valid_i), .irq_o(irq_o));
`default_nettype wire

// [logic/meter_cal_pkg.sv]
// Constants, register map and carrier types of the meter calibration datapath
package meter_cal_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PHASE_TRIM = 8'h00;
   localparam logic [7:0] OFS_VOLT_OFS = 8'h04;
   localparam logic [7:0] OFS_CURR_OFS = 8'h08;
   localparam logic [7:0] OFS_GAIN = 8'h0C;
   localparam logic [7:0] OFS_DIVIDER = 8'h10;
   localparam logic [7:0] OFS_LINE_CYCLES = 8'h14;
   localparam logic [7:0] OFS_MODE = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_VOLT_RMS = 8'h24;
   localparam logic [7:0] OFS_CURR_RMS = 8'h28;
   localparam logic [7:0] OFS_VA_TOTAL = 8'h2C;
   localparam logic [7:0] OFS_VA_LINE = 8'h30;
   localparam logic [7:0] OFS_ACT_LINE = 8'h34;
   // Reset values
   localparam logic [5:0] RST_PHASE_TRIM = 6'h0D;
   localparam logic [11:0] RST_OFS = 12'h000;
   localparam logic [7:0] RST_DIVIDER = 8'h01;
   localparam logic [15:0] RST_LINE_CYCLES = 16'h0000;
   // Field positions
   localparam int MODE_LINE_BIT = 0;
   localparam int ST_ZX_BIT = 0;
   localparam int ST_LINE_BIT = 1;
   localparam int STATUS_W = 2;
   // Datapath shape
   localparam int DELAY_DEPTH = 64;
   localparam logic [5:0] CURR_TAP = 6'h2D;
   localparam int LPF_SHIFT = 8;
   localparam int GAIN_FRAC = 12;
   localparam int ENERGY_SHIFT = 16;
   localparam logic signed [13:0] GAIN_ONE = 14'sh1000;

   typedef struct packed {
      logic signed [15:0] volt;
      logic signed [15:0] curr;
      logic signed [31:0] active;
   } sample_t;

   typedef enum {LC_IDLE, LC_RUN} lc_state_t;
endpackage

// [logic/meter_calibration_datapath.sv]
// Phase trim, rms with offset, apparent energy scaling and line-cycle results behind an APB slave
//
// Functional notes
// - Voltage samples are shifted in time, delayed or advanced, under phase_trim.
// - Shift equals phase_trim minus 0x0D sample periods of eight master clocks.
// - Positive difference delays, negative advances, 0x0D gives no shift.
// - phase_trim is read as a signed two's complement value.
// - Trim range covers 1.84 degree leads and 0.72 degree lags at 50 Hz.
// - Rms is square, low-pass filter, then square root.
// - Voltage rms adds volt_rms_offset after the low-pass stage.
// - volt_rms_offset is a 12-bit signed value.
// - Squared current rms gains 32768 times curr_rms_offset before the root.
// - Apparent energy scaled by one over divider and one plus gain over 4096.
// - Line-cycle mode latches active and apparent energy with an interrupt.
// - Interrupt output can be set to flag voltage zero crossings.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module meter_calibration_datapath (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sample_valid_i,
   input wire meter_cal_pkg::sample_t sample_i,
   output logic irq_o
);
   function automatic logic [15:0] isqrt(input logic [31:0] x);
      logic [15:0] r;
      logic [15:0] t;
      logic [31:0] sq;
      r = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         t = r | (16'h0001 << i);
         sq = {16'h0000, t} * {16'h0000, t};
         if (sq <= x) begin
            r = t;
         end
      end
      return r;
   endfunction

   // Software registers
   logic [5:0] phase_trim_q;
   logic [11:0] volt_ofs_q;
   logic [11:0] curr_ofs_q;
   logic [11:0] gain_q;
   logic [7:0] divider_q;
   logic [15:0] line_cycles_q;
   logic line_mode_q;
   logic [meter_cal_pkg::STATUS_W-1:0] status_q;
   logic [meter_cal_pkg::STATUS_W-1:0] mask_q;
   // Bus and interrupt output flops
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   // Datapath state
   logic signed [15:0] vline_q [meter_cal_pkg::DELAY_DEPTH];
   logic signed [15:0] cline_q [meter_cal_pkg::DELAY_DEPTH];
   logic [39:0] vacc_q;
   logic [39:0] iacc_q;
   logic [15:0] volt_rms_q;
   logic [15:0] curr_rms_q;
   logic [7:0] va_rem_q;
   logic [31:0] va_total_q;
   logic [31:0] lc_va_q;
   logic signed [31:0] lc_act_q;
   logic [31:0] va_line_q;
   logic [31:0] act_line_q;
   logic [15:0] half_cnt_q;
   logic vsign_q;
   meter_cal_pkg::lc_state_t lc_state_q;

   // Bus decode
   wire access = psel_i & penable_i;
   wire first_access = access & ~pready_q;
   wire wr_en = access & pready_q & pwrite_i;
   wire addr_hit = (paddr_i[1:0] == 2'h0) && (paddr_i <= meter_cal_pkg::OFS_ACT_LINE);
   wire wr_status = wr_en && (paddr_i == meter_cal_pkg::OFS_STATUS);
   logic [31:0] rd_data;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (paddr_i)
         meter_cal_pkg::OFS_PHASE_TRIM: rd_data = {{26{phase_trim_q[5]}}, phase_trim_q};
         meter_cal_pkg::OFS_VOLT_OFS: rd_data = {{20{volt_ofs_q[11]}}, volt_ofs_q};
         meter_cal_pkg::OFS_CURR_OFS: rd_data = {{20{curr_ofs_q[11]}}, curr_ofs_q};
         meter_cal_pkg::OFS_GAIN: rd_data = {{20{gain_q[11]}}, gain_q};
         meter_cal_pkg::OFS_DIVIDER: rd_data = {24'h000000, divider_q};
         meter_cal_pkg::OFS_LINE_CYCLES: rd_data = {16'h0000, line_cycles_q};
         meter_cal_pkg::OFS_MODE: rd_data = {31'h0000_0000, line_mode_q};
         meter_cal_pkg::OFS_STATUS: rd_data = {30'h0000_0000, status_q};
         meter_cal_pkg::OFS_MASK: rd_data = {30'h0000_0000, mask_q};
         meter_cal_pkg::OFS_VOLT_RMS: rd_data = {16'h0000, volt_rms_q};
         meter_cal_pkg::OFS_CURR_RMS: rd_data = {16'h0000, curr_rms_q};
         meter_cal_pkg::OFS_VA_TOTAL: rd_data = va_total_q;
         meter_cal_pkg::OFS_VA_LINE: rd_data = va_line_q;
         meter_cal_pkg::OFS_ACT_LINE: rd_data = act_line_q;
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // Phase trim: current waits a fixed 45 samples, the voltage tap is the signed trim plus 32
   // Shift is trim minus 0x0D samples, so -32..31 spans a 45-sample advance to an 18-sample delay
   // Two 64-deep sample lines in flops are the price of honouring every signed trim
   wire [5:0] v_idx = {~phase_trim_q[5], phase_trim_q[4:0]};
   wire signed [15:0] v_tap = vline_q[v_idx];
   wire signed [15:0] c_tap = cline_q[meter_cal_pkg::CURR_TAP];

   // Squares and mean squares
   wire [31:0] v_sq = 32'(v_tap * v_tap);
   wire [31:0] i_sq = 32'(c_tap * c_tap);
   wire [39:0] vacc_d = vacc_q + {8'h00, v_sq} - (vacc_q >> meter_cal_pkg::LPF_SHIFT);
   wire [39:0] iacc_d = iacc_q + {8'h00, i_sq} - (iacc_q >> meter_cal_pkg::LPF_SHIFT);
   wire [31:0] v_ms = vacc_q[meter_cal_pkg::LPF_SHIFT +: 32];
   wire [31:0] i_ms = iacc_q[meter_cal_pkg::LPF_SHIFT +: 32];

   // Current offset enters the mean square, scaled by 32768
   wire signed [33:0] i_corr = $signed({2'b00, i_ms}) + $signed({{7{curr_ofs_q[11]}}, curr_ofs_q, 15'h0000});
   wire [31:0] i_arg = i_corr[33] ? 32'h0000_0000 : (i_corr[32] ? 32'hFFFF_FFFF : i_corr[31:0]);
   wire [15:0] curr_rms_value_d = isqrt(i_arg);

   // Voltage offset enters after the root, clamped to the unsigned range
   wire [15:0] v_raw = isqrt(v_ms);
   wire signed [17:0] v_corr = $signed({2'b00, v_raw}) + $signed({{6{volt_ofs_q[11]}}, volt_ofs_q});
   wire [15:0] volt_rms_value_d = v_corr[17] ? 16'h0000 : (v_corr[16] ? 16'hFFFF : v_corr[15:0]);

   // Apparent energy: gain, then divide with remainder carried so no energy is lost
   wire [31:0] va = {16'h0000, volt_rms_q} * {16'h0000, curr_rms_q};
   wire signed [13:0] gain_fac = $signed({{2{gain_q[11]}}, gain_q}) + meter_cal_pkg::GAIN_ONE;
   wire [44:0] va_prod = {13'h0000, va} * {32'h0000_0000, gain_fac[12:0]};
   wire [16:0] va_inc = va_prod[meter_cal_pkg::GAIN_FRAC + meter_cal_pkg::ENERGY_SHIFT +: 17];
   wire [7:0] div_eff = (divider_q == 8'h00) ? 8'h01 : divider_q;
   wire [17:0] va_tot = {1'b0, va_inc} + {10'h000, va_rem_q};
   wire [17:0] va_quot = va_tot / {10'h000, div_eff};
   wire [17:0] va_mod = va_tot % {10'h000, div_eff};
   wire [31:0] lc_va_sum = lc_va_q + {14'h0000, va_quot};
   wire signed [31:0] lc_act_sum = lc_act_q + sample_i.active;

   // Zero crossing and line-cycle window
   // Sign is taken at the shifted tap, so crossings follow the phase trim
   wire zx_evt = sample_valid_i & (v_tap[15] != vsign_q);
   wire lc_run = (lc_state_q == meter_cal_pkg::LC_RUN);
   wire lc_done = lc_run & zx_evt & ((half_cnt_q + 16'h0001) == line_cycles_q);
   logic [meter_cal_pkg::STATUS_W-1:0] evt;
   logic [meter_cal_pkg::STATUS_W-1:0] status_d;
   meter_cal_pkg::lc_state_t lc_state_d;

   always_comb begin
      evt = '0;
      evt[meter_cal_pkg::ST_ZX_BIT] = zx_evt;
      evt[meter_cal_pkg::ST_LINE_BIT] = lc_done;
      // A clear in the same cycle as an event loses to the event
      status_d = (status_q & ~(wr_status ? pwdata_i[meter_cal_pkg::STATUS_W-1:0] : '0)) | evt;
   end

   always_comb begin
      lc_state_d = lc_state_q;
      case (lc_state_q)
         meter_cal_pkg::LC_IDLE: begin
            if (line_mode_q && line_cycles_q != 16'h0000) begin
               lc_state_d = meter_cal_pkg::LC_RUN;
            end
         end
         meter_cal_pkg::LC_RUN: begin
            if (!line_mode_q || line_cycles_q == 16'h0000) begin
               lc_state_d = meter_cal_pkg::LC_IDLE;
            end
         end
         default: lc_state_d = meter_cal_pkg::LC_IDLE;
      endcase
   end

   // APB slave: one wait state, answer from flops
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         pready_q <= first_access;
         pslverr_q <= first_access & ~addr_hit;
         prdata_q <= (first_access && !pwrite_i && addr_hit) ? rd_data : 32'h0000_0000;
         irq_q <= |(status_d & mask_q);
      end
   end

   // Settings are plain registers read by the datapath on each new sample
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         phase_trim_q <= meter_cal_pkg::RST_PHASE_TRIM;
         volt_ofs_q <= meter_cal_pkg::RST_OFS;
         curr_ofs_q <= meter_cal_pkg::RST_OFS;
         gain_q <= meter_cal_pkg::RST_OFS;
         divider_q <= meter_cal_pkg::RST_DIVIDER;
         line_cycles_q <= meter_cal_pkg::RST_LINE_CYCLES;
         line_mode_q <= 1'b0;
         mask_q <= '0;
      end else if (wr_en) begin
         case (paddr_i)
            meter_cal_pkg::OFS_PHASE_TRIM: phase_trim_q <= pwdata_i[5:0];
            meter_cal_pkg::OFS_VOLT_OFS: volt_ofs_q <= pwdata_i[11:0];
            meter_cal_pkg::OFS_CURR_OFS: curr_ofs_q <= pwdata_i[11:0];
            meter_cal_pkg::OFS_GAIN: gain_q <= pwdata_i[11:0];
            meter_cal_pkg::OFS_DIVIDER: divider_q <= pwdata_i[7:0];
            meter_cal_pkg::OFS_LINE_CYCLES: line_cycles_q <= pwdata_i[15:0];
            meter_cal_pkg::OFS_MODE: line_mode_q <= pwdata_i[meter_cal_pkg::MODE_LINE_BIT];
            meter_cal_pkg::OFS_MASK: mask_q <= pwdata_i[meter_cal_pkg::STATUS_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         status_q <= '0;
         lc_state_q <= meter_cal_pkg::LC_IDLE;
      end else begin
         status_q <= status_d;
         lc_state_q <= lc_state_d;
      end
   end

   // Sample delay lines
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < meter_cal_pkg::DELAY_DEPTH; i++) begin
            vline_q[i] <= 16'sh0000;
            cline_q[i] <= 16'sh0000;
         end
      end else if (sample_valid_i) begin
         vline_q[0] <= sample_i.volt;
         cline_q[0] <= sample_i.curr;
         for (int i = 1; i < meter_cal_pkg::DELAY_DEPTH; i++) begin
            vline_q[i] <= vline_q[i-1];
            cline_q[i] <= cline_q[i-1];
         end
      end
   end

   // Rms filters and apparent energy total; results move once per sample
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         vacc_q <= 40'h00_0000_0000;
         iacc_q <= 40'h00_0000_0000;
         volt_rms_q <= 16'h0000;
         curr_rms_q <= 16'h0000;
         va_rem_q <= 8'h00;
         va_total_q <= 32'h0000_0000;
         vsign_q <= 1'b0;
      end else if (sample_valid_i) begin
         vacc_q <= vacc_d;
         iacc_q <= iacc_d;
         volt_rms_q <= volt_rms_value_d;
         curr_rms_q <= curr_rms_value_d;
         va_rem_q <= va_mod[7:0];
         va_total_q <= va_total_q + {14'h0000, va_quot};
         vsign_q <= v_tap[15];
      end
   end

   // Line-cycle accumulation: both energies latched together at the window end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lc_va_q <= 32'h0000_0000;
         lc_act_q <= 32'sh0000_0000;
         va_line_q <= 32'h0000_0000;
         act_line_q <= 32'h0000_0000;
         half_cnt_q <= 16'h0000;
      end else if (!lc_run) begin
         lc_va_q <= 32'h0000_0000;
         lc_act_q <= 32'sh0000_0000;
         half_cnt_q <= 16'h0000;
      end else if (lc_done) begin
         va_line_q <= lc_va_sum;
         act_line_q <= lc_act_sum;
         lc_va_q <= 32'h0000_0000;
         lc_act_q <= 32'sh0000_0000;
         half_cnt_q <= 16'h0000;
      end else if (sample_valid_i) begin
         lc_va_q <= lc_va_sum;
         lc_act_q <= lc_act_sum;
         half_cnt_q <= zx_evt ? half_cnt_q + 16'h0001 : half_cnt_q;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;
endmodule
`default_nettype wire
